/* File: verilog/ulf_pkg.sv */
// constants, types and helpers of the line format and baud generator block
package ulf_pkg;
	localparam int unsigned CLK_HZ      = 100_000_000;
	// register indices; byte address is four times the index
	localparam logic [2:0]  IDX_DIV_LO  = 3'h0;
	localparam logic [2:0]  IDX_DATA    = 3'h0;
	localparam logic [2:0]  IDX_DIV_HI  = 3'h1;
	localparam logic [2:0]  IDX_LFC     = 3'h3;
	localparam logic [2:0]  IDX_STAT    = 3'h5;
	localparam logic [2:0]  IDX_CSEL    = 3'h6;
	// line format control fields
	localparam int          LFC_WLEN    = 0;
	localparam int          LFC_STOP    = 2;
	localparam int          LFC_PAR_ON  = 3;
	localparam int          LFC_PAR_EVN = 4;
	localparam int          LFC_PAR_FIX = 5;
	localparam int          LFC_BREAK   = 6;
	localparam int          LFC_DIV_WIN = 7;
	// status fields
	localparam int          ST_RX_RDY   = 0;
	localparam int          ST_OVERRUN  = 1;
	localparam int          ST_PAR_ERR  = 2;
	localparam int          ST_FRM_ERR  = 3;
	localparam int          ST_THR_EMP  = 5;
	localparam int          ST_TX_EMP   = 6;
	// reset values
	localparam logic [7:0]  LFC_RST     = 8'h00;
	localparam logic [15:0] DIV_RST     = 16'h0000;
	localparam logic [1:0]  CSEL_RST    = 2'h0;
	// oversampling counts, in sixteen-times ticks
	localparam logic [4:0]  TICK_BIT    = 5'h10;
	localparam logic [4:0]  TICK_HALF   = 5'h08;
	localparam logic [4:0]  TICK_STOP15 = 5'h18;
	localparam logic [4:0]  TICK_STOP2  = 5'h20;
	// generator input clocks and their phase steps at the system rate
	localparam longint      SRC_1843_HZ = 1_843_200;
	localparam longint      SRC_3072_HZ = 3_072_000;
	localparam longint      SRC_8000_HZ = 8_000_000;
	localparam longint      SRC_TEST_HZ = 48_000_000;
	localparam logic [31:0] STEP_1843   = 32'((SRC_1843_HZ << 32) / CLK_HZ);
	localparam logic [31:0] STEP_3072   = 32'((SRC_3072_HZ << 32) / CLK_HZ);
	localparam logic [31:0] STEP_8000   = 32'((SRC_8000_HZ << 32) / CLK_HZ);
	localparam logic [31:0] STEP_TEST   = 32'((SRC_TEST_HZ << 32) / CLK_HZ);

	typedef enum logic [1:0] {
		SRC_1843 = 2'b00,
		SRC_3072 = 2'b01,
		SRC_8000 = 2'b10,
		SRC_TEST = 2'b11
	} ulf_src_e;

	typedef enum logic [2:0] {
		FR_IDLE  = 3'b000,
		FR_START = 3'b001,
		FR_DATA  = 3'b010,
		FR_PAR   = 3'b011,
		FR_STOP  = 3'b100
	} ulf_frame_e;

	// keep only the bits of the selected word length
	function automatic logic [7:0] data_mask(input logic [7:0] d, input logic [1:0] wl);
		data_mask = d & (8'hff >> (2'd3 - wl));
	endfunction

	// parity bit for masked data
	function automatic logic par_bit(input logic [7:0] d, input logic even, input logic fixed);
		if (fixed) begin
			par_bit = ~even;
		end else begin
			par_bit = even ? ^d : ~^d;
		end
	endfunction
endpackage

/* File: verilog/ulf_fmt_if.sv */
// character format and baud tick shared between the block's modules
interface ulf_fmt_if;
	logic [1:0] wlen;
	logic       par_on;
	logic       par_even;
	logic       par_fix;
	logic       rx_abort;
	logic       tick16;

	modport ctl (output wlen, output par_on, output par_even, output par_fix, output rx_abort, input tick16);
	modport gen (output tick16);
	modport rx  (input wlen, input par_on, input par_even, input par_fix, input rx_abort, input tick16);
endinterface

/* File: verilog/ulf_baud_gen.sv */
// selectable generator input clock and sixteen-times divisor counter
module ulf_baud_gen (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic [1:0]  src_sel,
	input  wire logic [15:0] divisor,
	input  wire logic        reload,
	ulf_fmt_if.gen           f
);
	logic [31:0] acc_r;
	logic [31:0] step;
	logic [32:0] sum;
	logic [15:0] cnt_r;
	logic        tick_r;

	always_comb begin
		unique case (ulf_pkg::ulf_src_e'(src_sel))
			ulf_pkg::SRC_1843: step = ulf_pkg::STEP_1843;
			ulf_pkg::SRC_3072: step = ulf_pkg::STEP_3072;
			ulf_pkg::SRC_8000: step = ulf_pkg::STEP_8000;
			ulf_pkg::SRC_TEST: step = ulf_pkg::STEP_TEST;
		endcase
	end

	// carry out marks one edge of the generator input clock
	assign sum = {1'b0, acc_r} + {1'b0, step};

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			acc_r <= 32'h0000_0000;
		end else if (ce) begin
			acc_r <= sum[31:0];
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r  <= ulf_pkg::DIV_RST;
			tick_r <= 1'b0;
		end else if (ce) begin
			tick_r <= 1'b0;
			if (reload) begin
				cnt_r <= divisor;
			end else if (sum[32]) begin
				if (cnt_r <= 16'h0001) begin
					tick_r <= 1'b1;
					cnt_r  <= divisor;
				end else begin
					cnt_r <= cnt_r - 16'h0001;
				end
			end
		end
	end

	assign f.tick16 = tick_r;
endmodule

/* File: verilog/ulf_rx.sv */
// receiver: pin synchroniser, start detection, data, parity and stop sampling
module ulf_rx (
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic       ce,
	input  wire logic       sin,
	ulf_fmt_if.rx           f,
	output logic [7:0]      rx_data,
	output logic            rx_done,
	output logic            rx_perr,
	output logic            rx_ferr
);
	logic [2:0]            sync_r;
	logic                  line_r;
	ulf_pkg::ulf_frame_e   st_r;
	logic [4:0]            cnt_r;
	logic [2:0]            bit_r;
	logic [7:0]            sh_r;
	logic [7:0]            word;
	logic                  samp;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sync_r <= 3'h7;
			line_r <= 1'b1;
		end else if (ce) begin
			sync_r <= {sync_r[1:0], sin};
			if (sync_r[1] == sync_r[2]) begin
				line_r <= sync_r[2];
			end
		end
	end

	assign word = sh_r >> (2'd3 - f.wlen);
	assign samp = f.tick16 && (cnt_r == ulf_pkg::TICK_BIT - 5'h01);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_r    <= ulf_pkg::FR_IDLE;
			cnt_r   <= 5'h00;
			bit_r   <= 3'h0;
			sh_r    <= 8'h00;
			rx_data <= 8'h00;
			rx_done <= 1'b0;
			rx_perr <= 1'b0;
			rx_ferr <= 1'b0;
		end else if (ce) begin
			rx_done <= 1'b0;
			if (f.rx_abort) begin
				st_r <= ulf_pkg::FR_IDLE;
			end else if (f.tick16) begin
				cnt_r <= cnt_r + 5'h01;
				unique case (st_r)
					ulf_pkg::FR_IDLE: begin
						cnt_r <= 5'h00;
						if (!line_r) begin
							st_r <= ulf_pkg::FR_START;
						end
					end
					ulf_pkg::FR_START: begin
						if (cnt_r == ulf_pkg::TICK_HALF - 5'h01) begin
							cnt_r <= 5'h00;
							bit_r <= 3'h0;
							rx_perr <= 1'b0;
							st_r  <= line_r ? ulf_pkg::FR_IDLE : ulf_pkg::FR_DATA;
						end
					end
					ulf_pkg::FR_DATA: begin
						if (samp) begin
							cnt_r <= 5'h00;
							sh_r  <= {line_r, sh_r[7:1]};
							bit_r <= bit_r + 3'h1;
							if (bit_r == {1'b1, f.wlen}) begin
								st_r <= f.par_on ? ulf_pkg::FR_PAR : ulf_pkg::FR_STOP;
							end
						end
					end
					ulf_pkg::FR_PAR: begin
						if (samp) begin
							cnt_r   <= 5'h00;
							rx_perr <= line_r != ulf_pkg::par_bit(word, f.par_even, f.par_fix);
							st_r    <= ulf_pkg::FR_STOP;
						end
					end
					ulf_pkg::FR_STOP: begin
						if (samp) begin
							rx_data <= word;
							rx_ferr <= ~line_r;
							rx_done <= 1'b1;
							st_r    <= ulf_pkg::FR_IDLE;
						end
					end
					default: st_r <= ulf_pkg::FR_IDLE;
				endcase
			end
		end
	end
endmodule

/* File: verilog/ulf_line_format.sv */
// line format control, baud divisor and serial transmitter behind an APB slave
module ulf_line_format (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [4:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sin,
	output logic             sout
);
	ulf_fmt_if f ();

	logic [7:0]          lfc_r;
	logic [7:0]          div_lo_r;
	logic [7:0]          div_hi_r;
	logic [1:0]          csel_r;
	logic [15:0]         div_nxt;
	logic [7:0]          rd_val;
	logic [2:0]          idx;
	logic                hit;
	logic                acc;
	logic                wr_go;
	logic                rd_go;
	logic                win;
	logic                div_wr;
	logic                thr_wr;
	logic                rbr_rd;
	logic                st_rd;
	logic [7:0]          thr_r;
	logic                thr_full_r;
	logic                tx_take;
	ulf_pkg::ulf_frame_e tx_st_r;
	logic [4:0]          tx_cnt_r;
	logic [2:0]          tx_bit_r;
	logic [7:0]          tx_sh_r;
	logic [7:0]          tx_char_r;
	logic                tx_line_r;
	logic [4:0]          stop_len;
	logic [7:0]          rbr_r;
	logic                rx_rdy_r;
	logic                ovr_r;
	logic                perr_r;
	logic                ferr_r;
	logic [7:0]          rx_data;
	logic                rx_done;
	logic                rx_perr;
	logic                rx_ferr;
	logic [7:0]          status;

	// register decode
	assign idx    = paddr[4:2];
	assign win    = lfc_r[ulf_pkg::LFC_DIV_WIN];
	assign hit    = (paddr[1:0] == 2'b00) && (idx == ulf_pkg::IDX_DATA || idx == ulf_pkg::IDX_DIV_HI
		|| idx == ulf_pkg::IDX_LFC || idx == ulf_pkg::IDX_STAT || idx == ulf_pkg::IDX_CSEL);
	assign acc    = psel && penable && !pready;
	assign wr_go  = psel && penable && pready && pwrite && !pslverr;
	assign rd_go  = psel && penable && pready && !pwrite && !pslverr;
	assign div_wr = wr_go && win && (idx == ulf_pkg::IDX_DIV_LO || idx == ulf_pkg::IDX_DIV_HI);
	assign thr_wr = wr_go && !win && idx == ulf_pkg::IDX_DATA;
	assign rbr_rd = rd_go && !win && idx == ulf_pkg::IDX_DATA;
	assign st_rd  = rd_go && idx == ulf_pkg::IDX_STAT;

	assign status = {1'b0, thr_full_r == 1'b0 && tx_st_r == ulf_pkg::FR_IDLE, ~thr_full_r,
		2'b00, perr_r | 1'b0, 1'b0, 1'b0} | {4'h0, ferr_r, 1'b0, ovr_r, rx_rdy_r} ^ {5'h00, perr_r, 2'b00};

	always_comb begin
		rd_val = 8'h00;
		unique case (idx)
			ulf_pkg::IDX_DATA:   rd_val = win ? div_lo_r : rbr_r;
			ulf_pkg::IDX_DIV_HI: rd_val = win ? div_hi_r : 8'h00;
			ulf_pkg::IDX_LFC:    rd_val = lfc_r;
			ulf_pkg::IDX_STAT:   rd_val = status;
			ulf_pkg::IDX_CSEL:   rd_val = {6'h00, csel_r};
			default:             rd_val = 8'h00;
		endcase
	end

	// APB answer: one wait cycle, read data latched with pready
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			pready <= acc;
			if (acc) begin
				pslverr <= !hit;
				prdata  <= (hit && !pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// software registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lfc_r    <= ulf_pkg::LFC_RST;
			div_lo_r <= ulf_pkg::DIV_RST[7:0];
			div_hi_r <= ulf_pkg::DIV_RST[15:8];
			csel_r   <= ulf_pkg::CSEL_RST;
		end else if (ce && wr_go) begin
			if (idx == ulf_pkg::IDX_LFC) begin
				lfc_r <= pwdata[7:0];
			end
			if (div_wr && idx == ulf_pkg::IDX_DIV_LO) begin
				div_lo_r <= pwdata[7:0];
			end
			if (div_wr && idx == ulf_pkg::IDX_DIV_HI) begin
				div_hi_r <= pwdata[7:0];
			end
			if (idx == ulf_pkg::IDX_CSEL) begin
				csel_r <= pwdata[1:0];
			end
		end
	end

	// format fields to receiver and transmitter
	assign f.wlen     = lfc_r[ulf_pkg::LFC_WLEN +: 2];
	assign f.par_on   = lfc_r[ulf_pkg::LFC_PAR_ON];
	assign f.par_even = lfc_r[ulf_pkg::LFC_PAR_EVN];
	assign f.par_fix  = lfc_r[ulf_pkg::LFC_PAR_FIX];
	assign f.rx_abort = div_wr;

	// divisor as it stands after this cycle's write, so a reload takes the new byte
	assign div_nxt = {(div_wr && idx == ulf_pkg::IDX_DIV_HI) ? pwdata[7:0] : div_hi_r,
		(div_wr && idx == ulf_pkg::IDX_DIV_LO) ? pwdata[7:0] : div_lo_r};

	ulf_baud_gen u_gen (
		.mclk    (mclk),
		.reset_n (reset_n),
		.ce      (ce),
		.src_sel (csel_r),
		.divisor (div_nxt),
		.reload  (div_wr),
		.f       (f)
	);

	ulf_rx u_rx (
		.mclk    (mclk),
		.reset_n (reset_n),
		.ce      (ce),
		.sin     (sin),
		.f       (f),
		.rx_data (rx_data),
		.rx_done (rx_done),
		.rx_perr (rx_perr),
		.rx_ferr (rx_ferr)
	);

	// receive buffer and sticky flags; a new event wins over the clearing read
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rbr_r    <= 8'h00;
			rx_rdy_r <= 1'b0;
			ovr_r    <= 1'b0;
			perr_r   <= 1'b0;
			ferr_r   <= 1'b0;
		end else if (ce) begin
			if (rbr_rd) begin
				rx_rdy_r <= 1'b0;
			end
			if (st_rd) begin
				ovr_r  <= 1'b0;
				perr_r <= 1'b0;
				ferr_r <= 1'b0;
			end
			if (rx_done) begin
				rbr_r    <= rx_data;
				rx_rdy_r <= 1'b1;
				if (rx_rdy_r && !rbr_rd) begin
					ovr_r <= 1'b1;
				end
				if (rx_perr) begin
					perr_r <= 1'b1;
				end
				if (rx_ferr) begin
					ferr_r <= 1'b1;
				end
			end
		end
	end

	// holding register; a divisor write drops a waiting character
	assign tx_take = f.tick16 && tx_st_r == ulf_pkg::FR_IDLE && thr_full_r;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			thr_r      <= 8'h00;
			thr_full_r <= 1'b0;
		end else if (ce) begin
			if (thr_wr) begin
				thr_r      <= pwdata[7:0];
				thr_full_r <= 1'b1;
			end else if (tx_take || div_wr) begin
				thr_full_r <= 1'b0;
			end
		end
	end

	always_comb begin
		if (!lfc_r[ulf_pkg::LFC_STOP]) begin
			stop_len = ulf_pkg::TICK_BIT;
		end else if (f.wlen == 2'b00) begin
			stop_len = ulf_pkg::TICK_STOP15;
		end else begin
			stop_len = ulf_pkg::TICK_STOP2;
		end
	end

	// transmitter; a frame in progress always runs to its end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_st_r   <= ulf_pkg::FR_IDLE;
			tx_cnt_r  <= 5'h00;
			tx_bit_r  <= 3'h0;
			tx_sh_r   <= 8'h00;
			tx_char_r <= 8'h00;
			tx_line_r <= 1'b1;
		end else if (ce && f.tick16) begin
			tx_cnt_r <= tx_cnt_r + 5'h01;
			unique case (tx_st_r)
				ulf_pkg::FR_IDLE: begin
					tx_cnt_r  <= 5'h00;
					tx_line_r <= 1'b1;
					if (thr_full_r) begin
						tx_sh_r   <= thr_r;
						tx_char_r <= ulf_pkg::data_mask(thr_r, f.wlen);
						tx_line_r <= 1'b0;
						tx_st_r   <= ulf_pkg::FR_START;
					end
				end
				ulf_pkg::FR_START: begin
					if (tx_cnt_r == ulf_pkg::TICK_BIT - 5'h01) begin
						tx_cnt_r  <= 5'h00;
						tx_bit_r  <= 3'h0;
						tx_line_r <= tx_sh_r[0];
						tx_st_r   <= ulf_pkg::FR_DATA;
					end
				end
				ulf_pkg::FR_DATA: begin
					if (tx_cnt_r == ulf_pkg::TICK_BIT - 5'h01) begin
						tx_cnt_r <= 5'h00;
						tx_bit_r <= tx_bit_r + 3'h1;
						tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
						if (tx_bit_r == {1'b1, f.wlen}) begin
							if (f.par_on) begin
								tx_line_r <= ulf_pkg::par_bit(tx_char_r, f.par_even, f.par_fix);
								tx_st_r   <= ulf_pkg::FR_PAR;
							end else begin
								tx_line_r <= 1'b1;
								tx_st_r   <= ulf_pkg::FR_STOP;
							end
						end else begin
							tx_line_r <= tx_sh_r[1];
						end
					end
				end
				ulf_pkg::FR_PAR: begin
					if (tx_cnt_r == ulf_pkg::TICK_BIT - 5'h01) begin
						tx_cnt_r  <= 5'h00;
						tx_line_r <= 1'b1;
						tx_st_r   <= ulf_pkg::FR_STOP;
					end
				end
				ulf_pkg::FR_STOP: begin
					if (tx_cnt_r == stop_len - 5'h01) begin
						tx_cnt_r <= 5'h00;
						tx_st_r  <= ulf_pkg::FR_IDLE;
					end
				end
				default: tx_st_r <= ulf_pkg::FR_IDLE;
			endcase
		end
	end

	// break level overrides the transmitter
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sout <= 1'b1;
		end else if (ce) begin
			sout <= tx_line_r & ~lfc_r[ulf_pkg::LFC_BREAK];
		end
	end
endmodule

/* File: bench/ulf_line_format_asserts.sv */
// port checker of the line format block
module ulf_line_format_asserts (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [4:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sin,
	input wire logic        sout
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] lfc_r;
	logic       acc;

	assign acc = psel && penable && !pready && ce;

	// shadow of the format register as last written
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lfc_r <= 8'h00;
		end else if (psel && penable && pready && pwrite && paddr == 5'h0C) begin
			lfc_r <= pwdata[7:0];
		end
	end

	default clocking @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	one_wait_a: assert property (acc |=> pready) else $error("no answer after one wait");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	unaligned_a: assert property (acc && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0000_0000)
		else $error("unaligned access not refused");
	unmapped_a: assert property (acc && paddr[1:0] == 2'h0 && paddr[4:2] inside {3'h2, 3'h4, 3'h7} |=> pslverr)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (acc && paddr inside {5'h00, 5'h04, 5'h0C, 5'h14, 5'h18} |=> !pslverr)
		else $error("mapped access refused");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000) else $error("read data above byte");
	format_read_a: assert property (acc && !pwrite && paddr == 5'h0C |=> prdata[7:0] == lfc_r)
		else $error("format register readback wrong");
	idle_high_a: assert property ($rose(reset_n) |-> sout) else $error("line not idle after reset");
endmodule

bind ulf_line_format ulf_line_format_asserts i_ulf_line_format_asserts (.mclk(mclk), .reset_n(reset_n), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sin(sin), .sout(sout));

/* File: bench/ulf_remote.sv */
// remote terminal model on the asynchronous line
module ulf_remote (
	input  wire logic sout,
	output logic      sin
);
	timeunit 1ns;
	timeprecision 100ps;
	real bit_ns = 1000.0;

	initial sin = 1'b1;

	// sample n bits after the start bit at bit centres
	task automatic take(input int n, output logic [11:0] bits, output realtime t0);
		bits = 12'hfff;
		wait (sout === 1'b0);
		t0 = $realtime;
		#(bit_ns * 1.5);
		for (int i = 0; i < n; i++) begin
			bits[i] = sout;
			if (i < n - 1) begin
				#(bit_ns);
			end
		end
	endtask

	// start bit, then n bits lsb first, line back to mark
	task automatic send(input int n, input logic [11:0] bits);
		sin = 1'b0;
		#(bit_ns);
		for (int i = 0; i < n; i++) begin
			sin = bits[i];
			#(bit_ns);
		end
		sin = 1'b1;
	endtask
endmodule

/* File: bench/ulf_line_format_tb.sv */
// self-checking bench of the line format block
module ulf_line_format_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk;
	logic        reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [4:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sin;
	logic        sout;
	logic        ce;
	int          error_cnt;
	int          check_count;
	logic [31:0] rd;
	logic        er;
	logic [4:0]  ra [6] = '{5'h0C, 5'h18, 5'h14, 5'h04, 5'h08, 5'h0D};
	logic [7:0]  rv [6] = '{8'h00, 8'h00, 8'h60, 8'h00, 8'h00, 8'h00};
	longint      hz [4] = '{ulf_pkg::SRC_1843_HZ, ulf_pkg::SRC_3072_HZ, ulf_pkg::SRC_8000_HZ, ulf_pkg::SRC_TEST_HZ};

	ulf_line_format i_ulf_line_format (.mclk(mclk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sin(sin), .sout(sout));
	ulf_remote i_ulf_remote (.sout(sout), .sin(sin));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [4:0] a, input logic [7:0] d);
		int t;
		t = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		if (t >= 50) begin
			error_cnt++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic setdiv(input logic [7:0] lo, input logic [7:0] f);
		apb(1'b1, 5'h0C, 8'h80);
		apb(1'b1, 5'h00, lo);
		apb(1'b1, 5'h04, 8'h00);
		apb(1'b1, 5'h0C, f);
	endtask

	task automatic txwait;
		int t;
		t = 0;
		do begin
			apb(1'b0, 5'h14, 8'h00);
			t++;
		end while (rd[6] !== 1'b1 && t < 3000);
		chk("tx drained", 32'(rd[6]), 32'h0000_0001);
	endtask

	// start bit width against the expected bit time
	task automatic meas(input real exp);
		realtime t;
		wait (sout === 1'b0);
		t = $realtime;
		wait (sout === 1'b1);
		t = $realtime - t - exp;
		chk("bit time", 32'(t < 25.0 && t > -25.0), 32'h0000_0001);
	endtask

	// expected bits after the start bit, first stop bit included
	function automatic logic [11:0] frame(input logic [7:0] f, input logic [7:0] d, input logic bad, output int n);
		int w;
		int ones;
		w = 5 + int'(f[1:0]);
		ones = 0;
		frame = 12'hfff;
		for (int i = 0; i < w; i++) begin
			frame[i] = d[i];
			ones += d[i];
		end
		n = w + 1;
		if (f[3]) begin
			frame[w] = (f[5] ? !f[4] : ((ones % 2 == 0) ^ f[4])) ^ bad;
			n++;
		end
	endfunction

	initial begin
		#1_000_000;
		error_cnt++;
		end_sim();
	end

	initial begin
		logic [7:0]  lfc;
		logic [7:0]  a;
		logic [7:0]  b;
		logic        bad;
		logic [15:0] dv;
		logic [11:0] fa;
		logic [11:0] fb;
		logic [11:0] ga;
		logic [11:0] gb;
		realtime     ta;
		realtime     tb2;
		int          n;
		int          ex;
		int          dt;
		reset_n = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 5'h00;
		pwdata = 32'h0000_0000;
		error_cnt = 0;
		check_count = 0;
		void'($urandom(82));
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, ra[i], 8'h00);
			chk("reset read", rd, 32'(rv[i]));
			chk("refusal", 32'(er), 32'(i > 3));
		end
		dv = 16'($urandom);
		apb(1'b1, 5'h0C, 8'h80);
		apb(1'b0, 5'h0C, 8'h00);
		chk("format reg", rd, 32'h0000_0080);
		apb(1'b1, 5'h00, dv[7:0]);
		apb(1'b1, 5'h04, dv[15:8]);
		apb(1'b0, 5'h00, 8'h00);
		chk("divisor low", rd, 32'(dv[7:0]));
		apb(1'b0, 5'h04, 8'h00);
		chk("divisor high", rd, 32'(dv[15:8]));
		setdiv(8'h01, 8'h00);
		apb(1'b1, 5'h18, 8'h03);
		i_ulf_remote.bit_ns = 16.0e9 / 48.0e6;
		$display("register test done");
		for (int k = 0; k < 16; k++) begin
			lfc = {2'b00, 2'($urandom), 4'(k)};
			a = 8'($urandom);
			b = 8'($urandom);
			bad = 1'($urandom);
			apb(1'b1, 5'h0C, lfc);
			fa = frame(lfc, a, 1'b0, n);
			fb = frame(lfc, b, 1'b0, n);
			ex = 16 * n + 16 + (lfc[2] ? (lfc[1:0] == 2'b00 ? 8 : 16) : 0);
			fork
				begin
					i_ulf_remote.take(n, ga, ta);
					i_ulf_remote.take(n, gb, tb2);
				end
			join_none
			apb(1'b1, 5'h00, a);
			apb(1'b1, 5'h00, b);
			wait fork;
			chk("tx frame a", 32'(ga), 32'(fa));
			chk("tx frame b", 32'(gb), 32'(fb));
			dt = $rtoi((tb2 - ta) * 16.0 / i_ulf_remote.bit_ns + 0.5) - ex;
			chk("frame spacing", 32'(dt == 0 || dt == 1), 32'h0000_0001);
			i_ulf_remote.send(n, frame(lfc, a, bad, n));
			repeat (8) @(posedge mclk);
			apb(1'b0, 5'h14, 8'h00);
			chk("rx status", rd, 32'h0000_0061 | (32'(bad & lfc[3]) << 2));
			apb(1'b0, 5'h00, 8'h00);
			chk("rx data", rd, 32'(a & (8'hff >> (2'd3 - lfc[1:0]))));
		end
		$display("format test done");
		apb(1'b1, 5'h0C, 8'h03);
		apb(1'b1, 5'h00, 8'h55);
		apb(1'b1, 5'h00, 8'h0F);
		fork
			i_ulf_remote.send(9, 12'hfff);
		join_none
		repeat (100) @(posedge mclk);
		setdiv(8'h03, 8'h03);
		wait fork;
		repeat (1200) @(posedge mclk);
		apb(1'b0, 5'h14, 8'h00);
		chk("idle after divisor", rd, 32'h0000_0060);
		apb(1'b1, 5'h00, 8'h01);
		meas(16.0e9 * 3.0 / 48.0e6);
		txwait();
		$display("divisor test done");
		setdiv(8'h01, 8'h00);
		for (int s = 3; s >= 0; s--) begin
			apb(1'b1, 5'h18, 8'(s));
			apb(1'b1, 5'h00, 8'h01);
			meas(16.0e9 / real'(hz[s]));
			txwait();
		end
		$display("clock source test done");
		apb(1'b1, 5'h0C, 8'h40);
		repeat (2) @(posedge mclk);
		chk("break level", 32'(sout), 32'h0000_0000);
		apb(1'b1, 5'h0C, 8'h03);
		repeat (2) @(posedge mclk);
		chk("break release", 32'(sout), 32'h0000_0001);
		ce <= 1'b0;
		fork
			begin
				repeat (20) @(posedge mclk);
				ce <= 1'b1;
			end
		join_none
		ta = $realtime;
		apb(1'b0, 5'h0C, 8'h00);
		chk("frozen bus", 32'($realtime - ta > 200.0), 32'h0000_0001);
		chk("frozen read", rd, 32'h0000_0003);
		$display("break and enable test done");
		end_sim();
	end
endmodule
